// >>> hw/dptu_pkg.sv
package dptu_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PERIOD1 = 8'h04;
  localparam logic [7:0] OFS_PERIOD2 = 8'h08;
  localparam logic [7:0] OFS_DUTY1   = 8'h0c;
  localparam logic [7:0] OFS_DUTY2   = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_CLEAR   = 8'h18;
  localparam logic [7:0] OFS_ENABLE  = 8'h1c;

  // Control register field positions
  localparam int unsigned CTL_PRE1_LSB = 0;
  localparam int unsigned CTL_PRE2_LSB = 2;
  localparam int unsigned CTL_GATE1    = 4;
  localparam int unsigned CTL_GATE2    = 5;
  localparam int unsigned CTL_OUT1_EN  = 6;
  localparam int unsigned CTL_OUT2_EN  = 7;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Prescale terminal counts (ratio minus one) for codes 00..11
  localparam logic [5:0] PRE_TERM_2  = 6'h01;
  localparam logic [5:0] PRE_TERM_8  = 6'h07;
  localparam logic [5:0] PRE_TERM_32 = 6'h1f;
  localparam logic [5:0] PRE_TERM_64 = 6'h3f;

  // Last of the four sub-count steps per counter increment
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per-channel configuration as carried to the channel logic
  typedef struct packed {
    logic       out_en;
    logic       gate;
    logic [1:0] prescale;
  } dptu_chan_cfg_t;

  // AXI4-Lite request / answer groups
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } dptu_axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } dptu_axi_rsp_t;

endpackage

// >>> hw/dptu_top.sv
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module dptu_top #(
  parameter int unsigned CNT_W = 10
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  // Register bus
  input  wire dptu_pkg::dptu_axi_req_t axi_req,
  output dptu_pkg::dptu_axi_rsp_t      axi_rsp,
  // Modulated outputs and interrupt
  output logic                         modulated_output_1,
  output logic                         modulated_output_2,
  output logic                         irq
);
  import dptu_pkg::*;

  // Elaboration check: counter must fit in the 16-bit data lanes used
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("dptu_top: CNT_W must lie between 2 and 16");
  end

  // Reset synchroniser; release is clocked, assertion is immediate
  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // Software-visible state
  logic [7:0]       pwm_timer_control;
  logic [CNT_W-1:0] period_register [2];
  logic [CNT_W-1:0] duty_register   [2];
  logic [1:0]       period_match_flag;
  logic [1:0]       interrupt_enable_register;
  logic [1:0]       match_pulse;

  // Write channel holding registers
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic [1:0]        clear_req;

  // Per-channel configuration split out of the control register
  dptu_chan_cfg_t chan_cfg [2];
  assign chan_cfg[0] = '{out_en:   pwm_timer_control[CTL_OUT1_EN],
                         gate:     pwm_timer_control[CTL_GATE1],
                         prescale: pwm_timer_control[CTL_PRE1_LSB +: 2]};
  assign chan_cfg[1] = '{out_en:   pwm_timer_control[CTL_OUT2_EN],
                         gate:     pwm_timer_control[CTL_GATE2],
                         prescale: pwm_timer_control[CTL_PRE2_LSB +: 2]};

  // Answer-side state; the bus struct has a single driver below
  logic              b_valid;
  logic [1:0]        b_resp;
  logic              r_valid;
  logic [DATA_W-1:0] r_data;
  logic [1:0]        r_resp;
  logic              aw_ready;
  logic              w_ready;
  logic              ar_ready;

  // Handshake outputs; each direction takes nothing new while its own response is pending
  assign aw_ready = !aw_held && !b_valid;
  assign w_ready  = !w_held && !b_valid;
  assign ar_ready = !r_valid;
  assign do_write = aw_held && w_held && !b_valid;

  // Whole answer struct assembled in one place
  assign axi_rsp = '{awready: aw_ready, wready: w_ready, bvalid: b_valid,
                     bresp: b_resp, arready: ar_ready, rvalid: r_valid,
                     rdata: r_data, rresp: r_resp};

  // Address and data captured in either order
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_held <= 1'b1;
        aw_addr <= axi_req.awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_held <= 1'b1;
        w_data <= axi_req.wdata;
        w_strb <= axi_req.wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only targets answer SLVERR
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      b_valid <= 1'b0;
      b_resp  <= RESP_OKAY;
    end else if (do_write) begin
      b_valid <= 1'b1;
      unique case (aw_addr)
        OFS_CONTROL, OFS_PERIOD1, OFS_PERIOD2, OFS_DUTY1, OFS_DUTY2,
        OFS_CLEAR, OFS_ENABLE: b_resp <= RESP_OKAY;
        default:               b_resp <= RESP_SLVERR;
      endcase
    end else if (axi_req.bready) begin
      b_valid <= 1'b0;
    end
  end

  // Merge byte lanes 0 and 1 into an old value
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) res[7:0]  = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res;
  endfunction

  // Control and interrupt enable registers
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pwm_timer_control         <= CONTROL_RESET;
      interrupt_enable_register <= '0;
    end else if (do_write) begin
      if (aw_addr == OFS_CONTROL && w_strb[0]) begin
        pwm_timer_control <= w_data[7:0];
      end
      if (aw_addr == OFS_ENABLE && w_strb[0]) begin
        interrupt_enable_register <= w_data[1:0];
      end
    end
  end

  // Period and duty registers; duty accepted at any time
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      period_register <= '{default: '0};
      duty_register   <= '{default: '0};
    end else if (do_write) begin
      unique case (aw_addr)
        OFS_PERIOD1: period_register[0] <= CNT_W'(lane_merge(
                       16'(period_register[0]), w_data, w_strb));
        OFS_PERIOD2: period_register[1] <= CNT_W'(lane_merge(
                       16'(period_register[1]), w_data, w_strb));
        OFS_DUTY1:   duty_register[0] <= CNT_W'(lane_merge(
                       16'(duty_register[0]), w_data, w_strb));
        OFS_DUTY2:   duty_register[1] <= CNT_W'(lane_merge(
                       16'(duty_register[1]), w_data, w_strb));
        default: ;
      endcase
    end
  end

  // Write-one-to-clear request for the match flags
  assign clear_req = (do_write && aw_addr == OFS_CLEAR && w_strb[0]) ?
                     w_data[1:0] : 2'b00;

  // Sticky match flags; a match in the clearing cycle wins
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      period_match_flag <= '0;
    end else begin
      period_match_flag <= (period_match_flag & ~clear_req) | match_pulse;
    end
  end

  // Level interrupt while any enabled flag is set
  assign irq = |(period_match_flag & interrupt_enable_register);

  // Read path; counters are deliberately not mapped
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      r_valid <= 1'b0;
      r_data  <= '0;
      r_resp  <= RESP_OKAY;
    end else if (axi_req.arvalid && ar_ready) begin
      r_valid <= 1'b1;
      r_resp  <= RESP_OKAY;
      unique case (axi_req.araddr)
        OFS_CONTROL: r_data <= DATA_W'(pwm_timer_control);
        OFS_PERIOD1: r_data <= DATA_W'(period_register[0]);
        OFS_PERIOD2: r_data <= DATA_W'(period_register[1]);
        OFS_DUTY1:   r_data <= DATA_W'(duty_register[0]);
        OFS_DUTY2:   r_data <= DATA_W'(duty_register[1]);
        OFS_STATUS:  r_data <= DATA_W'(period_match_flag);
        OFS_ENABLE:  r_data <= DATA_W'(interrupt_enable_register);
        OFS_CLEAR:   r_data <= '0; // Write-only, reads zero
        default: begin
          r_data <= '0;
          r_resp <= RESP_SLVERR;
        end
      endcase
    end else if (axi_req.rready) begin
      r_valid <= 1'b0;
    end
  end

  // Prescale code to terminal count
  function automatic logic [5:0] pre_term(input logic [1:0] code);
    logic [5:0] t;
    unique case (code)
      2'h0: t = PRE_TERM_2;
      2'h1: t = PRE_TERM_8;
      2'h2: t = PRE_TERM_32;
      2'h3: t = PRE_TERM_64;
    endcase
    return t;
  endfunction

  logic [1:0] pwm_level;

  // One timing channel per output
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [5:0]       pre_cnt;
    logic [1:0]       quarter;
    logic [CNT_W-1:0] channel_counter;
    logic [CNT_W-1:0] duty_latch;
    logic             level;
    logic             tick;
    logic             at_period;
    logic [CNT_W+1:0] fine_next;

    // Prescaled tick; a stopped gate holds everything still
    assign tick = chan_cfg[ch].gate &&
                  pre_cnt == pre_term(chan_cfg[ch].prescale);
    assign at_period = channel_counter == period_register[ch] &&
                       quarter == QUARTER_LAST;
    assign fine_next = {channel_counter, quarter} + (CNT_W+2)'(1);
    assign match_pulse[ch] = tick && at_period;

    // Prescaler; async reset clears it
    always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        pre_cnt <= '0;
      end else if (tick) begin
        pre_cnt <= '0;
      end else if (chan_cfg[ch].gate) begin
        pre_cnt <= pre_cnt + 6'h01;
      end
    end

    // Counter with a two-bit sub-step below it: four ticks per count
    always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        channel_counter <= '0;
        quarter         <= '0;
      end else if (tick) begin
        if (at_period) begin
          channel_counter <= '0;
          quarter         <= '0;
        end else begin
          channel_counter <= fine_next[CNT_W+1:2];
          quarter         <= fine_next[1:0];
        end
      end
    end

    // Duty latch loads only at the period match
    always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        duty_latch <= '0;
      end else if (tick && at_period) begin
        duty_latch <= duty_register[ch];
      end
    end

    // Output level: set at match unless duty is zero, cleared at duty
    always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        level <= 1'b0;
      end else if (tick) begin
        if (at_period) begin
          level <= duty_register[ch] != '0;
        end else if (fine_next == (CNT_W+2)'(duty_latch)) begin
          level <= 1'b0;
        end
      end
    end

    // Pin driven only while its output enable is set
    assign pwm_level[ch] = level && chan_cfg[ch].out_en;
  end

  // Output pins
  assign modulated_output_1 = pwm_level[0];
  assign modulated_output_2 = pwm_level[1];

endmodule // dptu_top

// >>> test/dptu_checker.sv
`timescale 1ns/1ps
module dptu_checker (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    rst_b,
  // Register bus
  input wire dptu_pkg::dptu_axi_req_t axi_req,
  input wire dptu_pkg::dptu_axi_rsp_t axi_rsp,
  // Outputs
  input wire logic                    modulated_output_1,
  input wire logic                    modulated_output_2,
  input wire logic                    irq
);
  import dptu_pkg::*;
  logic [7:0] ctl;
  logic [7:0] ctlp;
  logic [9:0] d1;
  logic [1:0] en;
  logic [1:0] enp;
  wire        o1 = modulated_output_1;
  wire        o2 = modulated_output_2;
  wire        wr = axi_req.awvalid && axi_rsp.awready
                   && axi_req.wvalid && axi_rsp.wready;
  // Shadow of writes, one cycle ahead of the design, so keep a delayed copy
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl  <= 8'h00;
      ctlp <= 8'h00;
      d1   <= 10'h000;
      en   <= 2'h0;
      enp  <= 2'h0;
    end else begin
      ctlp <= ctl;
      enp  <= en;
      if (wr && axi_req.awaddr == OFS_CONTROL) ctl <= axi_req.wdata[7:0];
      if (wr && axi_req.awaddr == OFS_DUTY1) d1 <= axi_req.wdata[9:0];
      if (wr && axi_req.awaddr == OFS_ENABLE) en <= axi_req.wdata[1:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_RST_QUIET: assert property ($rose(rst_b)
    |-> !irq && !o1 && !o2)
    else $error("outputs active right after reset");
  AST_OUT_OFF: assert property (!ctl[6] && !ctlp[6] |-> !o1)
    else $error("output 1 high while disabled");
  AST_GATE_HOLD: assert property (!ctl[4] && !ctlp[4]
    && ctl[6] == ctlp[6] |=> $stable(o1))
    else $error("output 1 moved while counter stopped");
  AST_DUTY_ZERO: assert property (d1 == 10'h0 && $past(d1) == 10'h0
    && $past(d1, 2) == 10'h0 |-> !$rose(o1))
    else $error("output 1 rose with zero duty");
  AST_HIGH_MIN: assert property ($rose(o1) |=> o1)
    else $error("output 1 high for one cycle only");
  AST_PERIOD_MIN: assert property ($rose(o1) |=> !$rose(o1) [*7])
    else $error("output 1 period below eight cycles");
  AST_IRQ_MASK: assert property (en == 2'h0
    && enp == 2'h0 |-> !irq)
    else $error("interrupt while all sources masked");
  AST_FLAG_IRQ: assert property ($rose(o1) && en[0] && enp[0]
    |-> ##[0:1] irq)
    else $error("no interrupt after period match");
endmodule // dptu_checker

bind dptu_top dptu_checker u_chk (
  .clock(clock), .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .modulated_output_1(modulated_output_1),
  .modulated_output_2(modulated_output_2), .irq(irq));

// >>> test/dptu_sw_model.sv
`timescale 1ns/1ps
module dptu_sw_model (
  // Clock
  input  wire logic                    clock,
  // Register bus, master side
  output dptu_pkg::dptu_axi_req_t      axi_req,
  input  wire dptu_pkg::dptu_axi_rsp_t axi_rsp
);
  import dptu_pkg::*;
  // Bus idle from time zero
  initial axi_req = '0;
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clock);
    axi_req.awaddr  <= a;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid  <= 1'b1;
    axi_req.bready  <= 1'b1;
    while (aw || w) begin
      @(posedge clock);
      if (axi_rsp.awready) aw = 1'b0;
      if (axi_rsp.wready) w = 1'b0;
      axi_req.awvalid <= aw;
      axi_req.wvalid  <= w;
      if (!w) axi_req.wdata <= ~d; // Released data must not look valid
    end
    do @(posedge clock); while (!axi_rsp.bvalid);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask
  // Read: address held until taken, answer taken at its own edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clock);
    axi_req.araddr  <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready  <= 1'b1;
    do @(posedge clock); while (!axi_rsp.arready);
    axi_req.arvalid <= 1'b0;
    do @(posedge clock); while (!axi_rsp.rvalid);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask
endmodule // dptu_sw_model

// >>> test/tb_dual_pwm_timer_unit.sv
`timescale 1ns/1ps
module tb_dual_pwm_timer_unit;
  import dptu_pkg::*;
  logic          clock = 1'b0;
  logic          rst_b;
  dptu_axi_req_t axi_req;
  dptu_axi_rsp_t axi_rsp;
  logic          mo1;
  logic          mo2;
  logic          irq;
  int            err_total;
  int            n_checks;
  int            cyc;
  int            rt[4] = '{2, 8, 32, 64};
  dptu_top dut (.clock(clock), .rst_b(rst_b), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .modulated_output_1(mo1),
    .modulated_output_2(mo2), .irq(irq));
  dptu_sw_model sw (.clock(clock), .axi_req(axi_req), .axi_rsp(axi_rsp));
  // Clock and a cycle count for pulse timing
  always #12.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task automatic wrx(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic [1:0] r;
    sw.wr(a, d, r);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    sw.rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic wait_lvl(input int ch, input logic v);
    do @(posedge clock); while ((ch ? mo2 : mo1) !== v);
  endtask
  // High time and period from one rising edge to the next
  task automatic meas(input int ch, output int hi, output int per);
    int t0;
    wait_lvl(ch, 0);
    wait_lvl(ch, 1);
    t0 = cyc;
    wait_lvl(ch, 0);
    hi = cyc - t0;
    wait_lvl(ch, 1);
    per = cyc - t0;
  endtask
  task automatic s_regs();
    rdx(OFS_CONTROL, 32'h0, RESP_OKAY);
    rdx(OFS_STATUS, 32'h0, RESP_OKAY);
    rdx(8'h20, 32'h0, RESP_SLVERR);
    wrx(OFS_STATUS, 32'h3, RESP_SLVERR);
    wrx(OFS_CONTROL, 32'h1a5, RESP_OKAY);
    rdx(OFS_CONTROL, 32'ha5, RESP_OKAY);
    wrx(OFS_PERIOD1, 32'hffff, RESP_OKAY);
    rdx(OFS_PERIOD1, 32'h3ff, RESP_OKAY);
    rdx(OFS_CLEAR, 32'h0, RESP_OKAY);
  endtask
  // Every prescale code on both channels, fresh reset each time
  task automatic s_pwm();
    int hi;
    int per;
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 4; c++) begin
        do_reset();
        wrx(ch ? OFS_PERIOD2 : OFS_PERIOD1, 32'h2, RESP_OKAY);
        wrx(ch ? OFS_DUTY2 : OFS_DUTY1, 32'h5, RESP_OKAY);
        wrx(OFS_CONTROL, ch ? 32'ha0 | (c << 2) : 32'h50 | c, RESP_OKAY);
        meas(ch, hi, per);
        chk("high", hi, 5 * rt[c]);
        chk("period", per, 12 * rt[c]);
      end
    end
  endtask
  // Duty written mid-period waits for the next match; zero duty stays low
  task automatic s_duty();
    int hi;
    int per;
    int t0;
    do_reset();
    wrx(OFS_PERIOD1, 32'h2, RESP_OKAY);
    wrx(OFS_DUTY1, 32'ha, RESP_OKAY);
    wrx(OFS_ENABLE, 32'h1, RESP_OKAY);
    wrx(OFS_CONTROL, 32'h50, RESP_OKAY);
    wait_lvl(0, 1);
    t0 = cyc;
    wrx(OFS_DUTY1, 32'h3, RESP_OKAY);
    wait_lvl(0, 0);
    chk("high old", cyc - t0, 32'h14);
    meas(0, hi, per);
    chk("high new", hi, 32'h6);
    chk("period", per, 32'h18);
    wrx(OFS_DUTY1, 32'h0, RESP_OKAY);
    repeat (36) @(posedge clock);
    repeat (24) begin
      @(posedge clock);
      chk("zero duty", {31'h0, mo1}, 32'h0);
    end
  endtask
  // Counter 2 as a plain timer with its pin off
  task automatic s_timer();
    do_reset();
    wrx(OFS_PERIOD2, 32'h1, RESP_OKAY);
    wrx(OFS_ENABLE, 32'h2, RESP_OKAY);
    wrx(OFS_CONTROL, 32'h20, RESP_OKAY);
    repeat (40) @(posedge clock);
    chk("timer pin", {31'h0, mo2}, 32'h0);
    chk("irq set", {31'h0, irq}, 32'h1);
    wrx(OFS_ENABLE, 32'h0, RESP_OKAY);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdx(OFS_STATUS, 32'h2, RESP_OKAY);
    wrx(OFS_CONTROL, 32'h00, RESP_OKAY);
    wrx(OFS_CLEAR, 32'h2, RESP_OKAY);
    repeat (40) @(posedge clock);
    rdx(OFS_STATUS, 32'h0, RESP_OKAY);
  endtask
  initial begin
    rst_b = 1'b0;
    err_total = 0;
    n_checks = 0;
    do_reset();
    s_regs();
    s_pwm();
    s_duty();
    s_timer();
    results();
  end
  // Watchdog: the run needs well under a fifth of this span
  initial begin
    #(25 * 60000);
    err_total++;
    results();
  end
endmodule // tb_dual_pwm_timer_unit
